// ---- aptc_pkg.sv ----
// package: register map, field layout and trigger codes for the pair trigger block
package aptc_pkg;
  localparam int AXI_AW = 8;
  localparam int DW = 32;
  localparam int NPAIR = 3;
  localparam int SELW = 5;
  // byte addresses
  localparam logic [AXI_AW-1:0] ADDR_CTRL_8_9 = 8'h00;
  localparam logic [AXI_AW-1:0] ADDR_CTRL_10_11 = 8'h04;
  localparam logic [AXI_AW-1:0] ADDR_IRQ_STATUS = 8'h08;
  localparam logic [AXI_AW-1:0] ADDR_IRQ_ENABLE = 8'h0C;
  localparam logic [AXI_AW-1:0] ADDR_IRQ_CLEAR = 8'h10;
  localparam logic [AXI_AW-1:0] ADDR_GLOBAL_SWTRIG = 8'h14;
  // field positions inside one pair byte
  localparam int FLD_IRQEN = 7;
  localparam int FLD_PEND = 6;
  localparam int FLD_SWT = 5;
  localparam int FLD_SEL_LO = 0;
  localparam int BYTE_W = 8;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  // trigger source codes
  localparam logic [SELW-1:0] SEL_OFF = 5'h00;
  localparam logic [SELW-1:0] SEL_SOFT = 5'h01;
  localparam logic [SELW-1:0] SEL_GSOFT = 5'h02;
  localparam logic [SELW-1:0] SEL_SEV = 5'h03;
  localparam logic [SELW-1:0] SEL_PRI_FIRST = 5'h04;
  localparam logic [SELW-1:0] SEL_PRI_LAST = 5'h0B;
  localparam logic [SELW-1:0] SEL_TMR1 = 5'h0C;
  localparam logic [SELW-1:0] SEL_SSEV = 5'h0D;
  localparam logic [SELW-1:0] SEL_SEC_FIRST = 5'h0E;
  localparam logic [SELW-1:0] SEL_SEC_LAST = 5'h16;
  localparam logic [SELW-1:0] SEL_CL_FIRST = 5'h17;
  localparam logic [SELW-1:0] SEL_CL_LAST = 5'h1E;
  localparam logic [SELW-1:0] SEL_TMR2 = 5'h1F;
  localparam int NPRI = 8;
  localparam int NSEC = 9;
  localparam int NCL = 8;
  // analog input numbers converted per pair (8, 10, 11)
  localparam logic [4:0] PAIR_AN_HI [NPAIR] = '{5'd17, 5'd21, 5'd23};
  localparam logic [4:0] PAIR_AN_LO [NPAIR] = '{5'd16, 5'd20, 5'd22};
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ---- aptc_adc_pair_trigger_control.sv ----
// top module: trigger selection and conversion requests for pairs 8, 10, 11
//
// The AXI4-Lite slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module aptc_adc_pair_trigger_control
  import aptc_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // axi4-lite write address, data and response
  input wire logic [aptc_pkg::AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [aptc_pkg::DW-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [aptc_pkg::AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [aptc_pkg::DW-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // trigger sources, one-cycle pulses
  input wire logic globalSoftTrig,
  input wire logic pwmSpecialEvent,
  input wire logic pwmSecSpecialEvent,
  input wire logic [aptc_pkg::NPRI-1:0] pwmPrimaryTrig,
  input wire logic [aptc_pkg::NSEC-1:0] pwmSecondaryTrig,
  input wire logic [aptc_pkg::NCL-1:0] pwmCurrentLimitTrig,
  input wire logic timer1Match,
  input wire logic timer2Match,
  // converter core
  output logic convStart,
  output logic [4:0] convAnHi,
  output logic [4:0] convAnLo,
  input wire logic convBusy,
  input wire logic convDone,
  // interrupts
  output logic pairIrq,
  output logic irq
);
  import aptc_pkg::*;

  typedef enum logic [1:0] {IDLE, START, WAIT} aptc_conv_t;

  logic [7:0] ctrlByte_ff [NPAIR];
  logic [7:0] pair89Hi_ff;
  logic [NPAIR-1:0] irqStatus_ff;
  logic [NPAIR-1:0] irqEnable_ff;
  logic [NPAIR-1:0] trigHit;
  logic [NPAIR-1:0] doneHit;
  logic [1:0] activePair_ff;
  aptc_conv_t state_ff;
  logic swGlobal_ff;
  logic gTrig;
  logic anyPend;
  logic [1:0] nxt_pick;

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  logic awHeld_ff;
  logic wHeld_ff;
  logic [AXI_AW-1:0] awAddr_ff;
  logic [DW-1:0] wData_ff;
  logic [3:0] wStrb_ff;
  logic doWrite;
  assign doWrite = awHeld_ff && wHeld_ff && !bvalid;

  always_ff @(posedge clk) begin
    if (reset) begin
      awHeld_ff <= 1'b0;
      wHeld_ff <= 1'b0;
      awAddr_ff <= '0;
      wData_ff <= '0;
      wStrb_ff <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld_ff <= 1'b1;
        awAddr_ff <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_ff <= 1'b1;
        wData_ff <= wdata;
        wStrb_ff <= wstrb;
      end
      if (doWrite) begin
        awHeld_ff <= 1'b0;
        wHeld_ff <= 1'b0;
        bvalid <= 1'b1;
        unique case (awAddr_ff)
          ADDR_CTRL_8_9, ADDR_CTRL_10_11, ADDR_IRQ_STATUS, ADDR_IRQ_ENABLE,
          ADDR_IRQ_CLEAR, ADDR_GLOBAL_SWTRIG: bresp <= RESP_OKAY;
          default: bresp <= RESP_SLVERR;
        endcase
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      awready <= 1'b0;
      wready <= 1'b0;
    end else begin
      awready <= !awHeld_ff && !(awvalid && awready) && !bvalid;
      wready <= !wHeld_ff && !(wvalid && wready) && !bvalid;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else begin
      arready <= !rvalid && !(arvalid && arready);
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rresp <= RESP_OKAY;
        unique case (araddr)
          ADDR_CTRL_8_9: rdata <= {16'h0000, pair89Hi_ff, ctrlByte_ff[0]};
          ADDR_CTRL_10_11:
            rdata <= {16'h0000, ctrlByte_ff[2], ctrlByte_ff[1]};
          ADDR_IRQ_STATUS: rdata <= {29'h0000_0000, irqStatus_ff};
          ADDR_IRQ_ENABLE: rdata <= {29'h0000_0000, irqEnable_ff};
          ADDR_IRQ_CLEAR, ADDR_GLOBAL_SWTRIG: rdata <= '0;
          default: begin
            rdata <= '0;
            rresp <= RESP_SLVERR;
          end
        endcase
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trigger selection per pair
  logic ctrlWr [NPAIR];
  assign ctrlWr[0] = doWrite && awAddr_ff == ADDR_CTRL_8_9 && wStrb_ff[0];
  assign ctrlWr[1] = doWrite && awAddr_ff == ADDR_CTRL_10_11 && wStrb_ff[0];
  assign ctrlWr[2] = doWrite && awAddr_ff == ADDR_CTRL_10_11 && wStrb_ff[1];

  // global soft trigger: external pulse or register write
  assign gTrig = globalSoftTrig || swGlobal_ff;

  always_ff @(posedge clk) begin
    if (reset) begin
      swGlobal_ff <= 1'b0;
      pair89Hi_ff <= CTRL_RESET[15:8];
    end else begin
      swGlobal_ff <= doWrite && awAddr_ff == ADDR_GLOBAL_SWTRIG
                     && wStrb_ff[0] && wData_ff[0];
      // pair 9 byte is storage only here; its logic lives elsewhere
      if (doWrite && awAddr_ff == ADDR_CTRL_8_9 && wStrb_ff[1])
        pair89Hi_ff <= wData_ff[15:8];
    end
  end

  generate
    for (genvar p = 0; p < NPAIR; p++) begin : g_pair
      logic [SELW-1:0] sel;
      logic [7:0] wb;
      logic src;
      assign sel = ctrlByte_ff[p][FLD_SEL_LO +: SELW];
      assign wb = (p == 2) ? wData_ff[15:8] : wData_ff[7:0];
      always_comb begin
        src = 1'b0;
        if (sel == SEL_OFF) src = 1'b0;
        else if (sel == SEL_SOFT) src = ctrlByte_ff[p][FLD_SWT];
        else if (sel == SEL_GSOFT) src = gTrig;
        else if (sel == SEL_SEV) src = pwmSpecialEvent;
        else if (sel <= SEL_PRI_LAST)
          src = pwmPrimaryTrig[3'(sel - SEL_PRI_FIRST)];
        else if (sel == SEL_TMR1) src = timer1Match;
        else if (sel == SEL_SSEV) src = pwmSecSpecialEvent;
        else if (sel <= SEL_SEC_LAST)
          src = pwmSecondaryTrig[4'(sel - SEL_SEC_FIRST)];
        else if (sel <= SEL_CL_LAST)
          src = pwmCurrentLimitTrig[3'(sel - SEL_CL_FIRST)];
        else src = timer2Match;
      end
      // a new trigger while already pending merges into that request
      assign trigHit[p] = src && !ctrlByte_ff[p][FLD_PEND];
      assign doneHit[p] = state_ff == WAIT && convDone
                          && activePair_ff == 2'(p);

      always_ff @(posedge clk) begin
        if (reset) begin
          ctrlByte_ff[p] <= CTRL_RESET[7:0];
        end else begin
          if (ctrlWr[p]) ctrlByte_ff[p] <= wb;
          if (trigHit[p]) begin
            ctrlByte_ff[p][FLD_PEND] <= 1'b1;
            ctrlByte_ff[p][FLD_SWT] <= 1'b0;
          end else if (doneHit[p]) begin
            ctrlByte_ff[p][FLD_PEND] <= 1'b0;
          end
        end
      end

      // irq status: set wins over clear
      always_ff @(posedge clk) begin
        if (reset) begin
          irqStatus_ff[p] <= 1'b0;
        end else if (doneHit[p] && ctrlByte_ff[p][FLD_IRQEN]) begin
          irqStatus_ff[p] <= 1'b1;
        end else if (doWrite && awAddr_ff == ADDR_IRQ_CLEAR
                     && wStrb_ff[0] && wData_ff[p]) begin
          irqStatus_ff[p] <= 1'b0;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // conversion sequencer: one pair at a time
  always_comb begin
    nxt_pick = 2'd0;
    for (int i = NPAIR - 1; i >= 0; i--)
      if (ctrlByte_ff[i][FLD_PEND]) nxt_pick = 2'(i);
  end
  assign anyPend = |{ctrlByte_ff[2][FLD_PEND], ctrlByte_ff[1][FLD_PEND],
                     ctrlByte_ff[0][FLD_PEND]};

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= IDLE;
      activePair_ff <= 2'd0;
      convStart <= 1'b0;
      convAnHi <= '0;
      convAnLo <= '0;
    end else begin
      convStart <= 1'b0;
      unique case (state_ff)
        IDLE: begin
          // hold the request until the core is free
          if (anyPend && !convBusy) begin
            activePair_ff <= nxt_pick;
            convAnHi <= PAIR_AN_HI[nxt_pick];
            convAnLo <= PAIR_AN_LO[nxt_pick];
            convStart <= 1'b1;
            state_ff <= START;
          end
        end
        START: state_ff <= WAIT;
        WAIT: if (convDone) state_ff <= IDLE;
        default: state_ff <= IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt
  always_ff @(posedge clk) begin
    if (reset) begin
      irqEnable_ff <= '0;
      irq <= 1'b0;
      pairIrq <= 1'b0;
    end else begin
      if (doWrite && awAddr_ff == ADDR_IRQ_ENABLE && wStrb_ff[0])
        irqEnable_ff <= wData_ff[NPAIR-1:0];
      irq <= |(irqStatus_ff & irqEnable_ff);
      pairIrq <= |doneHit & ctrlByte_ff[activePair_ff][FLD_IRQEN];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  // start pulse and START state stand in the same cycle
  sequence s_started;
    convStart && state_ff == START;
  endsequence
  property p_start_wait;
    @(posedge clk) disable iff (reset) s_started |=> state_ff == WAIT;
  endproperty
  a_start_wait: assert property (p_start_wait)
    else $error("sequencer did not wait after start");

  property p_busy_hold;
    @(posedge clk) disable iff (reset) convBusy |=> !convStart;
  endproperty
  a_busy_hold: assert property (p_busy_hold)
    else $error("start issued while converter busy");

  property p_pend_set;
    @(posedge clk) disable iff (reset) trigHit[0] |=> ctrlByte_ff[0][FLD_PEND];
  endproperty
  a_pend_set: assert property (p_pend_set)
    else $error("pending not set by trigger");

  property p_swt_clear;
    @(posedge clk) disable iff (reset)
      trigHit[1] |=> !ctrlByte_ff[1][FLD_SWT];
  endproperty
  a_swt_clear: assert property (p_swt_clear)
    else $error("soft trigger not cleared");

  property p_done_clear;
    @(posedge clk) disable iff (reset)
      doneHit[2] && !trigHit[2] && !ctrlWr[2] |=> !ctrlByte_ff[2][FLD_PEND];
  endproperty
  a_done_clear: assert property (p_done_clear)
    else $error("pending not cleared at completion");

  property p_irq_en;
    @(posedge clk) disable iff (reset)
      doneHit[0] && ctrlByte_ff[0][FLD_IRQEN] |=> irqStatus_ff[0] && pairIrq;
  endproperty
  a_irq_en: assert property (p_irq_en)
    else $error("enabled completion gave no irq");

  property p_off;
    @(posedge clk) disable iff (reset)
      ctrlByte_ff[1][FLD_SEL_LO +: SELW] == SEL_OFF |-> !trigHit[1];
  endproperty
  a_off: assert property (p_off)
    else $error("disabled pair triggered");

  property p_prio;
    @(posedge clk) disable iff (reset)
      state_ff == IDLE && !convBusy && ctrlByte_ff[0][FLD_PEND]
      |=> activePair_ff == 2'd0 && convAnHi == PAIR_AN_HI[0];
  endproperty
  a_prio: assert property (p_prio)
    else $error("lowest pair not served first");
endmodule

// ---- aptc_conv_model.sv ----
// converter core model: busy while converting, done pulse at the end
`timescale 1ns/1ps
module aptc_conv_model (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // request side
  input wire logic convStart,
  input wire logic [7:0] latency,
  input wire logic extBusy,
  // answer side
  output logic convBusy,
  output logic convDone
);
  logic run_ff;
  logic done_ff;
  logic [7:0] cnt_ff;
  ////////////////////////////////////////
  // extBusy stands for other conversions still holding the core
  assign convBusy = run_ff | extBusy;
  assign convDone = done_ff;
  always_ff @(posedge clk) begin
    if (reset) begin
      run_ff <= 1'b0;
      done_ff <= 1'b0;
      cnt_ff <= 8'h00;
    end else begin
      done_ff <= 1'b0;
      if (convStart && !run_ff) begin
        run_ff <= 1'b1;
        cnt_ff <= latency;
      end else if (run_ff && cnt_ff <= 8'h01) begin
        run_ff <= 1'b0;
        done_ff <= 1'b1;
      end else if (run_ff) begin
        cnt_ff <= cnt_ff - 8'h01;
      end
    end
  end
endmodule

// ---- aptc_adc_pair_trigger_control_tb.sv ----
// testbench: registers, trigger codes, priority and interrupts
`timescale 1ns/1ps
module aptc_adc_pair_trigger_control_tb;
  import aptc_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
  logic [DW-1:0] wdata = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, extBusy = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, convStart, convBusy;
  logic convDone, pairIrq, irq;
  logic [1:0] bresp, rresp;
  logic [4:0] convAnHi, convAnLo, lastHi, lastLo;
  logic [14:0] hist = '0;
  // bit n drives the source of selector code n, for codes 2 to 31; bits 0 and 1 drive nothing
  logic [31:0] trg = '0;
  logic [7:0] lat = 8'h0c;
  int errTotal = 0, checkCount = 0, startCnt = 0, irqCnt = 0;
  always #5 clk = ~clk;
  aptc_adc_pair_trigger_control dut_u (.clk, .reset, .awaddr, .awvalid,
    .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid,
    .bready(1'b1), .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready(1'b1), .globalSoftTrig(trg[2]), .pwmSpecialEvent(trg[3]),
    .pwmPrimaryTrig(trg[11:4]), .timer1Match(trg[12]),
    .pwmSecSpecialEvent(trg[13]), .pwmSecondaryTrig(trg[22:14]),
    .pwmCurrentLimitTrig(trg[30:23]), .timer2Match(trg[31]), .convStart,
    .convAnHi, .convAnLo, .convBusy, .convDone, .pairIrq, .irq);
  aptc_conv_model conv_u (.clk, .reset, .convStart, .latency(lat),
    .extBusy, .convBusy, .convDone);
  always @(posedge clk) begin
    if (convStart === 1'b1) begin
      startCnt <= startCnt + 1;
      lastHi <= convAnHi;
      lastLo <= convAnLo;
      hist <= {hist[9:0], convAnHi};
    end
    if (pairIrq === 1'b1) irqCnt <= irqCnt + 1;
  end
  ////////////////////////////////////////
  task automatic results();
    if (errTotal == 0 && checkCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checkCount++;
    if (g !== e) begin
      errTotal++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // both channels offered together, each dropped when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    int k;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    r = bresp;
    if (k == 100) begin
      chk("write timeout", 0, 1);
      results();
    end
  endtask
  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    int k;
    araddr <= a;
    arvalid <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    d = rdata;
    r = rresp;
    if (k == 100) begin
      chk("read timeout", 0, 1);
      results();
    end
  endtask
  task automatic pulse(input logic [31:0] v);
    trg <= v;
    @(posedge clk);
    trg <= '0;
  endtask
  // settle margin covers pending clear, pairIrq and irq lag
  task automatic waitStarts(input int n);
    int k;
    for (k = 0; k < 500; k++) begin
      @(posedge clk);
      if (startCnt >= n && convBusy === 1'b0) break;
    end
    if (k == 500) begin
      chk("conversion timeout", 0, 1);
      results();
    end else begin
      repeat (4) @(posedge clk);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    int c, p, w, sh, s0, i0;
    logic ie;
    logic [7:0] b, ad;
    logic [31:0] d;
    logic [1:0] r;
    void'($urandom(52759));
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (c = 0; c < 4; c++) begin
      axr(8'(4 * c), d, r);
      chk("reset value", {16'h0000, CTRL_RESET}, d);
    end
    axr(8'h40, d, r);
    chk("unmapped rdata", 32'h0000_0000, d);
    chk("unmapped rresp", RESP_SLVERR, r);
    axw(8'h40, 32'hffff_ffff, r);
    chk("unmapped bresp", RESP_SLVERR, r);
    axw(ADDR_IRQ_ENABLE, 32'h0000_0007, r);
    chk("bresp", RESP_OKAY, r);
    for (c = 0; c < 32; c++) begin
      p = $urandom_range(2, 0);
      ie = 1'($urandom_range(1, 0));
      lat <= 8'($urandom_range(30, 12));
      sh = (p == 2) ? 8 : 0;
      ad = (p == 0) ? ADDR_CTRL_8_9 : ADDR_CTRL_10_11;
      b = {ie, 2'b00, 5'(c)};
      axw(ad ^ 8'h04, 32'h0000_0000, r);
      axw(ad, {24'h00_0000, b} << sh, r);
      s0 = startCnt;
      i0 = irqCnt;
      if (c == 0) begin
        pulse(32'hffff_ffff);
        axw(ad, {24'h00_0000, b | 8'h20} << sh, r);
        repeat (8) @(posedge clk);
        chk("disabled pair", s0, startCnt);
      end else begin
        w = $urandom_range(31, 2);
        if (w == c) w = (c == 31) ? 2 : c + 1;
        pulse(32'h1 << w);
        repeat (6) @(posedge clk);
        chk("unselected source", s0, startCnt);
        if (c == 1) axw(ad, {24'h00_0000, b | 8'h20} << sh, r);
        else pulse(32'h1 << c);
        axr(ad, d, r);
        chk("pending", {24'h00_0000, b | 8'h40} << sh, d);
        waitStarts(s0 + 1);
        chk("start", s0 + 1, startCnt);
        chk("inputs", {PAIR_AN_HI[p], PAIR_AN_LO[p]}, {lastHi, lastLo});
        axr(ad, d, r);
        chk("complete", {24'h00_0000, b} << sh, d);
        chk("pair irq", i0 + int'(ie), irqCnt);
        chk("irq", ie, irq);
        axw(ADDR_IRQ_CLEAR, 32'h1 << p, r);
      end
    end
    // all three pairs fire together while the core is held busy
    extBusy <= 1'b1;
    lat <= 8'h03;
    axw(ADDR_CTRL_8_9, 32'h0000_0082, r);
    axw(ADDR_CTRL_10_11, 32'h0000_8282, r);
    s0 = startCnt;
    i0 = irqCnt;
    axw(ADDR_GLOBAL_SWTRIG, 32'h0000_0001, r);
    repeat (10) @(posedge clk);
    chk("start while busy", s0, startCnt);
    axr(ADDR_CTRL_10_11, d, r);
    chk("pending held", 32'h0000_c2c2, d);
    extBusy <= 1'b0;
    waitStarts(s0 + 3);
    chk("order", {PAIR_AN_HI[0], PAIR_AN_HI[1], PAIR_AN_HI[2]}, hist);
    chk("irq pulses", i0 + 3, irqCnt);
    axr(ADDR_IRQ_STATUS, d, r);
    chk("irq status", 32'h0000_0007, d);
    chk("irq level", 1, irq);
    axw(ADDR_IRQ_ENABLE, 32'h0000_0000, r);
    repeat (2) @(posedge clk);
    chk("irq masked", 0, irq);
    axw(ADDR_IRQ_ENABLE, 32'h0000_0007, r);
    axw(ADDR_IRQ_CLEAR, 32'h0000_0007, r);
    repeat (2) @(posedge clk);
    chk("irq cleared", 0, irq);
    axr(ADDR_IRQ_STATUS, d, r);
    chk("status cleared", 32'h0000_0000, d);
    results();
  end
endmodule
